// *** cbg_defines.svh ***
// Overview of operation
// - device acks its own address on write
// - index byte N follows, device acks it
// - count byte X follows, device acks it
// - device acks each of the X data bytes separately, not later ones
// - serial clock up to 400 kHz works
// - serial port serves only with running refclock
// - enable low starts output within 1-3 periods
// - enable high stops output low/low, 1-3 periods
// - outputs driven within 300 us after powerdown exit
// - first output clock within 1 ms
// - first power good samples straps, later toggles powerdown
// - tri-level strap picks one of three addresses
// - enable pins active low: 1 disables output
// - cleared enable bit forces output low/low
`ifndef CBG_DEFINES_SVH
`define CBG_DEFINES_SVH

// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define CBG_CORE_CLK_HZ      64'd25000000
`define CBG_TDRV_US          64'd300
`define CBG_TSTAB_MS         64'd1
`define CBG_TDRV_CYCLES      ((`CBG_TDRV_US * `CBG_CORE_CLK_HZ) / 64'd1000000)
`define CBG_TSTAB_CYCLES     ((`CBG_TSTAB_MS * `CBG_CORE_CLK_HZ) / 64'd1000)
`define CBG_MARGIN_CYCLES    64'd16
`define CBG_CLK_LOSS_CYCLES  8'h10
`define CBG_SMB_MAX_KHZ      400

// ------------------------------------------------------------
// target addresses per strap level
// ------------------------------------------------------------
`define CBG_ADDR_LOW         7'h6b
`define CBG_ADDR_MID         7'h6c
`define CBG_ADDR_HIGH        7'h6d
`define CBG_STRAP_LOW        2'h0
`define CBG_STRAP_MID        2'h1

// ------------------------------------------------------------
// register bytes
// ------------------------------------------------------------
`define CBG_OE_BYTE_INDEX    3'h0
`define CBG_BYTE_BITS        4'h8
`define CBG_REG_RESET        64'h08_00_00_ff_87_dd_06_dd

// output enable bit positions inside the enable byte
`define CBG_OE_BIT0          0
`define CBG_OE_BIT1          2
`define CBG_OE_BIT2          3
`define CBG_OE_BIT3          4
`define CBG_OE_BIT4          6
`define CBG_OE_BIT5          7

`endif

// *** cbg_pkg.sv ***
package cbg_pkg;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_RECV,
		BUS_ACK,
		BUS_WAIT
	} cbg_bus_state_type;

	typedef enum logic [1:0] {
		PH_ADDR,
		PH_INDEX,
		PH_COUNT,
		PH_DATA
	} cbg_phase_type;

	typedef enum logic [1:0] {
		PW_OFF,
		PW_WAIT,
		PW_RUN,
		PW_DOWN
	} cbg_power_state_type;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       pwr_good;
		logic [1:0] strap;
		logic       ref_tog;
	} cbg_core_pins_type;

	typedef struct packed {
		logic [5:0] oe_n;
		logic [5:0] cfg_en;
		logic       run;
	} cbg_ref_ctl_type;

	typedef struct packed {
		logic       en;
		logic [7:0] addr;
		logic [7:0] data;
	} cbg_wr_type;

	typedef struct packed {
		cbg_bus_state_type   bus;
		cbg_phase_type       phase;
		cbg_power_state_type pwr;
		logic [3:0]          bit_cnt;
		logic [7:0]          shift;
		logic [7:0]          index;
		logic [7:0]          count;
		logic [6:0]          target_addr;
		logic [15:0]         delay_cnt;
		logic                scl_prev;
		logic                sda_prev;
		logic                tog_prev;
		logic [7:0]          loss_cnt;
		logic                clk_running;
		logic                sda_oe;
		logic                sda_level;
		logic                run;
		cbg_wr_type          wr;
	} cbg_core_state_type;

	typedef struct packed {
		logic       tog;
		logic [5:0] p;
		logic [5:0] n;
	} cbg_ref_state_type;

endpackage

// *** cbg_sync.sv ***
module cbg_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// data
	input  wire logic [WIDTH-1:0] d_in,
	output logic      [WIDTH-1:0] q_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} cbg_sync_state_type;

	cbg_sync_state_type st_reg;
	cbg_sync_state_type st_next;

	always_comb begin
		st_next.meta   = d_in;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q_out = st_reg.stable;

endmodule // cbg_sync

// *** cbg_byte_mem.sv ***
module cbg_byte_mem #(
	parameter int                   WIDTH       = 8,
	parameter int                   DEPTH       = 8,
	parameter int                   AW          = 3,
	parameter logic [DEPTH*WIDTH-1:0] RESET_VALUE = '0
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	// write port
	input  wire logic             wr_en_in,
	input  wire logic [7:0]       wr_addr_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	// read port
	input  wire logic [AW-1:0]    rd_addr_in,
	output logic      [WIDTH-1:0] rd_data_out
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0]            rd;
	} cbg_mem_state_type;

	cbg_mem_state_type st_reg;
	cbg_mem_state_type st_next;

	always_comb begin
		st_next    = st_reg;
		st_next.rd = st_reg.mem[rd_addr_in];
		// indices past the top of the file are dropped
		if (wr_en_in && (32'(wr_addr_in) < DEPTH)) begin
			st_next.mem[wr_addr_in[AW-1:0]] = wr_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg.mem <= RESET_VALUE;
			st_reg.rd  <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data_out = st_reg.rd;

endmodule // cbg_byte_mem

// *** cbg_top.sv ***
`include "cbg_defines.svh"

module cbg_top #(
	parameter int         NUM_OUT      = 6,
	parameter logic [15:0] STAB_CYCLES =
		16'(`CBG_TSTAB_CYCLES - `CBG_MARGIN_CYCLES),
	parameter logic [15:0] DRV_CYCLES  =
		16'(`CBG_TDRV_CYCLES - `CBG_MARGIN_CYCLES),
	parameter logic [7:0]  LOSS_CYCLES = `CBG_CLK_LOSS_CYCLES
) (
	// core clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rst_in,
	// differential reference clock, link domain
	input  wire logic             ref_clk_in,
	// serial management pins
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe_out,
	// power and strap pins
	input  wire logic             power_good_down_n_in,
	input  wire logic [1:0]       target_addr_strap_in,
	// output enable pins
	input  wire logic [NUM_OUT-1:0] out_enable_n_in,
	// clock outputs
	output logic [NUM_OUT-1:0]    diff_clock_out_p_out,
	output logic [NUM_OUT-1:0]    diff_clock_out_n_out,
	// status
	output logic                  smbus_active_out,
	output logic                  outputs_run_out
);

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	cbg_pkg::cbg_core_state_type st_reg;
	cbg_pkg::cbg_core_state_type st_next;
	cbg_pkg::cbg_ref_state_type  rs_reg;
	cbg_pkg::cbg_ref_state_type  rs_next;
	cbg_pkg::cbg_core_pins_type  pins_raw;
	cbg_pkg::cbg_core_pins_type  pins_s;
	cbg_pkg::cbg_ref_ctl_type    ctl_raw;
	cbg_pkg::cbg_ref_ctl_type    ctl_s;
	logic [7:0]                  oe_byte;
	logic [5:0]                  cfg_en;
	logic                        scl_rise;
	logic                        scl_fall;
	logic                        start_cond;
	logic                        stop_cond;
	logic                        bus_active;

	// ------------------------------------------------------------
	// pin synchronisers into the core domain
	// ------------------------------------------------------------
	assign pins_raw.scl      = scl_in;
	assign pins_raw.sda      = sda_in;
	assign pins_raw.pwr_good = power_good_down_n_in;
	assign pins_raw.strap    = target_addr_strap_in;
	assign pins_raw.ref_tog  = rs_reg.tog;

	// sampling at 25 MHz leaves over 60 samples per 400 kHz bit
	cbg_sync #(
		.WIDTH ($bits(cbg_pkg::cbg_core_pins_type))
	) u_core_sync (
		.clk_in (core_clk_in),
		.rst_in (rst_in),
		.d_in   (pins_raw),
		.q_out  (pins_s)
	);

	// ------------------------------------------------------------
	// register bytes
	// ------------------------------------------------------------
	cbg_byte_mem #(
		.WIDTH       (8),
		.DEPTH       (8),
		.AW          (3),
		.RESET_VALUE (`CBG_REG_RESET)
	) u_regs (
		.clk_in      (core_clk_in),
		.rst_in      (rst_in),
		.wr_en_in    (st_reg.wr.en),
		.wr_addr_in  (st_reg.wr.addr),
		.wr_data_in  (st_reg.wr.data),
		.rd_addr_in  (`CBG_OE_BYTE_INDEX),
		.rd_data_out (oe_byte)
	);

	assign cfg_en = {oe_byte[`CBG_OE_BIT5], oe_byte[`CBG_OE_BIT4],
		oe_byte[`CBG_OE_BIT3], oe_byte[`CBG_OE_BIT2],
		oe_byte[`CBG_OE_BIT1], oe_byte[`CBG_OE_BIT0]};

	// ------------------------------------------------------------
	// bus conditions
	// ------------------------------------------------------------
	assign scl_rise   = pins_s.scl & ~st_reg.scl_prev;
	assign scl_fall   = ~pins_s.scl & st_reg.scl_prev;
	assign start_cond = pins_s.scl & st_reg.scl_prev &
		st_reg.sda_prev & ~pins_s.sda;
	assign stop_cond  = pins_s.scl & st_reg.scl_prev &
		~st_reg.sda_prev & pins_s.sda;
	// no strap sampled yet or reference clock lost: bus ignored
	assign bus_active = st_reg.clk_running &&
		(st_reg.pwr != cbg_pkg::PW_OFF);

	// ------------------------------------------------------------
	// core next state
	// ------------------------------------------------------------
	always_comb begin
		st_next           = st_reg;
		st_next.scl_prev  = pins_s.scl;
		st_next.sda_prev  = pins_s.sda;
		st_next.tog_prev  = pins_s.ref_tog;
		st_next.sda_level = 1'b0;
		st_next.wr.en     = 1'b0;

		// reference clock activity watch
		if (pins_s.ref_tog != st_reg.tog_prev) begin
			st_next.loss_cnt    = '0;
			st_next.clk_running = 1'b1;
		end else if (st_reg.loss_cnt == LOSS_CYCLES) begin
			st_next.clk_running = 1'b0;
		end else begin
			st_next.loss_cnt = st_reg.loss_cnt + 8'h01;
		end

		// power sequencing
		case (st_reg.pwr)
			cbg_pkg::PW_OFF: begin
				if (pins_s.pwr_good) begin
					// first high level latches the strap
					case (pins_s.strap)
						`CBG_STRAP_LOW: begin
							st_next.target_addr = `CBG_ADDR_LOW;
						end
						`CBG_STRAP_MID: begin
							st_next.target_addr = `CBG_ADDR_MID;
						end
						default: begin
							st_next.target_addr = `CBG_ADDR_HIGH;
						end
					endcase
					st_next.delay_cnt = STAB_CYCLES;
					st_next.pwr       = cbg_pkg::PW_WAIT;
				end
			end
			cbg_pkg::PW_WAIT: begin
				if (!pins_s.pwr_good) begin
					st_next.pwr = cbg_pkg::PW_DOWN;
				end else if (st_reg.delay_cnt == 16'h0000) begin
					st_next.pwr = cbg_pkg::PW_RUN;
				end else begin
					st_next.delay_cnt = st_reg.delay_cnt - 16'h0001;
				end
			end
			cbg_pkg::PW_RUN: begin
				if (!pins_s.pwr_good) begin
					st_next.pwr = cbg_pkg::PW_DOWN;
				end
			end
			cbg_pkg::PW_DOWN: begin
				if (pins_s.pwr_good) begin
					st_next.delay_cnt = DRV_CYCLES;
					st_next.pwr       = cbg_pkg::PW_WAIT;
				end
			end
			default: begin
				st_next.pwr = cbg_pkg::PW_OFF;
			end
		endcase
		st_next.run = (st_next.pwr == cbg_pkg::PW_RUN);

		// serial target
		if (!bus_active) begin
			st_next.bus    = cbg_pkg::BUS_IDLE;
			st_next.sda_oe = 1'b0;
		end else if (start_cond) begin
			st_next.bus     = cbg_pkg::BUS_RECV;
			st_next.phase   = cbg_pkg::PH_ADDR;
			st_next.bit_cnt = '0;
			st_next.sda_oe  = 1'b0;
		end else if (stop_cond) begin
			st_next.bus    = cbg_pkg::BUS_IDLE;
			st_next.sda_oe = 1'b0;
		end else begin
			case (st_reg.bus)
				cbg_pkg::BUS_RECV: begin
					if (scl_rise && (st_reg.bit_cnt != `CBG_BYTE_BITS)) begin
						st_next.shift   = {st_reg.shift[6:0], pins_s.sda};
						st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
					end else if (scl_fall &&
						(st_reg.bit_cnt == `CBG_BYTE_BITS)) begin
						st_next.bus    = cbg_pkg::BUS_ACK;
						st_next.sda_oe = 1'b1;
						case (st_reg.phase)
							cbg_pkg::PH_ADDR: begin
								if ((st_reg.shift[7:1] == st_reg.target_addr) &&
									!st_reg.shift[0]) begin
									st_next.phase = cbg_pkg::PH_INDEX;
								end else begin
									st_next.bus    = cbg_pkg::BUS_WAIT;
									st_next.sda_oe = 1'b0;
								end
							end
							cbg_pkg::PH_INDEX: begin
								st_next.index = st_reg.shift;
								st_next.phase = cbg_pkg::PH_COUNT;
							end
							cbg_pkg::PH_COUNT: begin
								st_next.count = st_reg.shift;
								st_next.phase = cbg_pkg::PH_DATA;
							end
							cbg_pkg::PH_DATA: begin
								if (st_reg.count != 8'h00) begin
									st_next.wr.en   = 1'b1;
									st_next.wr.addr = st_reg.index;
									st_next.wr.data = st_reg.shift;
									st_next.index   = st_reg.index + 8'h01;
									st_next.count   = st_reg.count - 8'h01;
								end else begin
									st_next.bus    = cbg_pkg::BUS_WAIT;
									st_next.sda_oe = 1'b0;
								end
							end
							default: begin
								st_next.bus    = cbg_pkg::BUS_WAIT;
								st_next.sda_oe = 1'b0;
							end
						endcase
					end
				end
				cbg_pkg::BUS_ACK: begin
					// hold data low through the ninth clock
					if (scl_fall) begin
						st_next.sda_oe  = 1'b0;
						st_next.bus     = cbg_pkg::BUS_RECV;
						st_next.bit_cnt = '0;
					end
				end
				cbg_pkg::BUS_WAIT: begin
					st_next.sda_oe = 1'b0;
				end
				cbg_pkg::BUS_IDLE: begin
					st_next.sda_oe = 1'b0;
				end
				default: begin
					st_next.bus    = cbg_pkg::BUS_IDLE;
					st_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// crossing into the reference clock domain
	// ------------------------------------------------------------
	assign ctl_raw.oe_n   = out_enable_n_in;
	assign ctl_raw.cfg_en = cfg_en;
	assign ctl_raw.run    = st_reg.run;

	cbg_sync #(
		.WIDTH ($bits(cbg_pkg::cbg_ref_ctl_type))
	) u_ref_sync (
		.clk_in (ref_clk_in),
		.rst_in (rst_in),
		.d_in   (ctl_raw),
		.q_out  (ctl_s)
	);

	// ------------------------------------------------------------
	// output gating on the reference clock
	// ------------------------------------------------------------
	always_comb begin
		rs_next     = rs_reg;
		rs_next.tog = ~rs_reg.tog;
		for (int i = 0; i < NUM_OUT; i++) begin
			// run, pin low and bit set enable; otherwise both legs low
			if (ctl_s.run && ctl_s.cfg_en[i] && !ctl_s.oe_n[i]) begin
				rs_next.p[i] = ~rs_reg.tog;
				rs_next.n[i] = rs_reg.tog;
			end else begin
				rs_next.p[i] = 1'b0;
				rs_next.n[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rs_reg <= '0;
		end else begin
			rs_reg <= rs_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign diff_clock_out_p_out = rs_reg.p;
	assign diff_clock_out_n_out = rs_reg.n;
	assign sda_out              = st_reg.sda_level;
	assign sda_oe_out           = st_reg.sda_oe;
	assign smbus_active_out     = st_reg.clk_running;
	assign outputs_run_out      = st_reg.run;

endmodule // cbg_top

// *** cbg_top_properties.sv ***
module cbg_top_chk #(
	parameter int          NUM_OUT     = 6,
	parameter logic [15:0] STAB_CYCLES = 16'h0014,
	parameter logic [15:0] DRV_CYCLES  = 16'h000a
) (
	// clocks and reset
	input wire logic               core_clk_in,
	input wire logic               rst_in,
	input wire logic               ref_clk_in,
	// serial pins
	input wire logic               scl_in,
	input wire logic               sda_out,
	input wire logic               sda_oe_out,
	// power and enables
	input wire logic               power_good_down_n_in,
	input wire logic [NUM_OUT-1:0] out_enable_n_in,
	// outputs and status
	input wire logic [NUM_OUT-1:0] diff_clock_out_p_out,
	input wire logic [NUM_OUT-1:0] diff_clock_out_n_out,
	input wire logic               smbus_active_out,
	input wire logic               outputs_run_out
);
	// ------------------------------------------------------------
	// cycles spent waiting for the outputs to start
	// ------------------------------------------------------------
	logic [15:0] wait_cnt_reg;
	logic [15:0] wait_cnt_next;

	always_comb begin
		wait_cnt_next = 16'h0000;
		if (power_good_down_n_in && smbus_active_out && !outputs_run_out)
			wait_cnt_next = wait_cnt_reg + 16'h0001;
	end

	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in)
			wait_cnt_reg <= 16'h0000;
		else
			wait_cnt_reg <= wait_cnt_next;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_drain_only: assert property (@(posedge core_clk_in)
		disable iff (rst_in) sda_oe_out |-> sda_out == 1'b0)
		else $error("data line driven high");
	a_ack_scl_low: assert property (@(posedge core_clk_in)
		disable iff (rst_in) $changed(sda_oe_out) |-> !scl_in)
		else $error("ack changed while clock high");
	a_ack_held: assert property (@(posedge core_clk_in)
		disable iff (rst_in) (sda_oe_out && scl_in) |=> sda_oe_out)
		else $error("ack dropped while clock high");
	a_ack_ends: assert property (@(posedge core_clk_in)
		disable iff (rst_in) $rose(sda_oe_out) |-> ##[1:400] !sda_oe_out)
		else $error("ack never released");
	a_no_ack_idle: assert property (@(posedge core_clk_in)
		disable iff (rst_in) (!smbus_active_out)[*2] |-> !sda_oe_out)
		else $error("ack while bus inactive");
	a_run_in_time: assert property (@(posedge core_clk_in)
		disable iff (rst_in) wait_cnt_reg <= STAB_CYCLES + 16'h0008)
		else $error("outputs late after power good");
	a_pd_stops: assert property (@(posedge core_clk_in)
		disable iff (rst_in)
		(!power_good_down_n_in)[*5] |-> !outputs_run_out)
		else $error("still running in power down");
	a_pd_legs: assert property (@(posedge ref_clk_in)
		disable iff (rst_in) (!outputs_run_out)[*5] |->
		(diff_clock_out_p_out | diff_clock_out_n_out) == '0)
		else $error("legs driven while stopped");
	a_legs_split: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(diff_clock_out_p_out & diff_clock_out_n_out) == '0)
		else $error("both legs high");
	a_legs_toggle: assert property (@(posedge ref_clk_in)
		disable iff (rst_in)
		(diff_clock_out_p_out & $past(diff_clock_out_p_out)) == '0)
		else $error("true leg not toggling");
	a_pin_off: assert property (@(posedge ref_clk_in)
		disable iff (rst_in) out_enable_n_in[0][*5] |->
		!diff_clock_out_p_out[0] && !diff_clock_out_n_out[0])
		else $error("disabled output still driven");
endmodule // cbg_top_chk

bind cbg_top cbg_top_chk #(
	.NUM_OUT(NUM_OUT),
	.STAB_CYCLES(STAB_CYCLES),
	.DRV_CYCLES(DRV_CYCLES)
) u_chk (
	.core_clk_in(core_clk_in),
	.rst_in(rst_in),
	.ref_clk_in(ref_clk_in),
	.scl_in(scl_in),
	.sda_out(sda_out),
	.sda_oe_out(sda_oe_out),
	.power_good_down_n_in(power_good_down_n_in),
	.out_enable_n_in(out_enable_n_in),
	.diff_clock_out_p_out(diff_clock_out_p_out),
	.diff_clock_out_n_out(diff_clock_out_n_out),
	.smbus_active_out(smbus_active_out),
	.outputs_run_out(outputs_run_out)
);

// *** cbg_smb_host.sv ***
module cbg_smb_host #(
	parameter int HALF = 33
) (
	// pacing clock
	input  wire logic clk_in,
	// bus pins
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_out
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic start_cond();
		sda_oe_out = 1'b1;
		hold(HALF);
		scl_out = 1'b0;
		hold(4);
	endtask

	task automatic put_bit(input logic b, output logic s);
		sda_oe_out = !b;
		hold(HALF);
		scl_out = 1'b1;
		hold(HALF);
		s = sda_in;
		scl_out = 1'b0;
		hold(4);
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i], s);
		put_bit(1'b1, s);
		ack = !s;
	endtask

	task automatic stop_cond();
		sda_oe_out = 1'b1;
		hold(HALF);
		scl_out = 1'b1;
		hold(HALF);
		sda_oe_out = 1'b0;
		hold(HALF);
	endtask
endmodule // cbg_smb_host

// *** cbg_top_test.sv ***
module cbg_top_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic       core_clk   = 1'b0;
	logic       ref_clk    = 1'b0;
	logic       ref_run    = 1'b1;
	logic       rst        = 1'b1;
	logic       pg         = 1'b0;
	logic [1:0] strap      = 2'h0;
	logic [5:0] oe_n       = 6'h00;
	logic       scl;
	logic       h_oe;
	logic       d_sda;
	logic       d_oe;
	logic       sda;
	logic [5:0] p;
	logic [5:0] n;
	logic       active;
	logic       run;
	logic [7:0] acks;
	logic [5:0] tog;
	logic [6:0] addr [3] = '{7'h6b, 7'h6c, 7'h6d};
	int         err_count  = 0;
	int         num_checks = 0;

	always #20 core_clk = ~core_clk;
	always #7.5 ref_clk = ref_run ? ~ref_clk : ref_clk;
	assign sda = (h_oe || (d_oe && !d_sda)) ? 1'b0 : 1'b1;

	cbg_top #(
		.STAB_CYCLES(16'h0014),
		.DRV_CYCLES(16'h000a)
	) dut (
		.core_clk_in(core_clk),
		.rst_in(rst),
		.ref_clk_in(ref_clk),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(d_sda),
		.sda_oe_out(d_oe),
		.power_good_down_n_in(pg),
		.target_addr_strap_in(strap),
		.out_enable_n_in(oe_n),
		.diff_clock_out_p_out(p),
		.diff_clock_out_n_out(n),
		.smbus_active_out(active),
		.outputs_run_out(run)
	);

	cbg_smb_host host (
		.clk_in(core_clk),
		.sda_in(sda),
		.scl_out(scl),
		.sda_oe_out(h_oe)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] q[$]);
		logic a;
		acks = 8'h00;
		host.start_cond();
		foreach (q[i]) begin
			host.send_byte(q[i], a);
			acks[i] = a;
		end
		host.stop_cond();
	endtask

	task automatic watch();
		logic [11:0] prev;
		repeat (6) @(posedge ref_clk);
		#1;
		tog = 6'h00;
		prev = {n, p};
		repeat (4) begin
			@(posedge ref_clk);
			#1;
			tog = tog | ((p ^ prev[5:0]) & (n ^ prev[11:6]));
			prev = {n, p};
		end
		chk("legs low", 8'h00, {2'h0, (p | n) & ~tog});
	endtask

	task automatic wait_run(input int lim);
		int c;
		c = 0;
		while (run !== 1'b1 && c < lim) begin
			@(posedge core_clk);
			#1;
			c++;
		end
		chk("run in time", 8'h01, {7'h00, run});
	endtask

	task automatic do_reset(input logic [1:0] s);
		rst = 1'b1;
		pg = 1'b0;
		strap = s;
		repeat (8) @(posedge core_clk);
		#1;
		rst = 1'b0;
		pg = 1'b1;
		wait_run(32);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_straps();
		for (int s = 0; s < 3; s++) begin
			do_reset(2'(s));
			wr('{{addr[s], 1'b0}});
			chk("own address", 8'h01, acks);
			wr('{{addr[(s + 1) % 3], 1'b0}});
			chk("other address", 8'h00, acks);
			wr('{{addr[s], 1'b1}});
			chk("read bit", 8'h00, acks);
		end
	endtask

	task automatic t_block();
		wr('{8'hda, 8'h00, 8'h02, 8'hff, 8'h00, 8'h55});
		chk("block acks", 8'h1f, acks);
		watch();
		chk("index advance", 8'h3f, {2'h0, tog});
		wr('{8'hda, 8'h00, 8'h01, 8'h5b});
		watch();
		chk("bit override", 8'h1d, {2'h0, tog});
		wr('{8'hda, 8'h00, 8'h00, 8'hff});
		chk("zero count", 8'h07, acks);
		watch();
		chk("not stored", 8'h1d, {2'h0, tog});
		wr('{8'hda, 8'h00, 8'h01, 8'hff});
	endtask

	task automatic t_pins();
		for (int i = 0; i < 6; i++) begin
			@(posedge core_clk);
			#1;
			oe_n = 6'(1 << i);
			watch();
			chk("pin gating", {2'h0, ~oe_n}, {2'h0, tog});
		end
		@(posedge core_clk);
		#1;
		oe_n = 6'h00;
		watch();
		chk("pins on", 8'h3f, {2'h0, tog});
	endtask

	task automatic t_ref_stop();
		ref_run = 1'b0;
		repeat (40) @(posedge core_clk);
		#1;
		chk("bus active", 8'h00, {7'h00, active});
		wr('{8'hda});
		chk("ack no refclk", 8'h00, acks);
		ref_run = 1'b1;
		repeat (40) @(posedge core_clk);
		#1;
		wr('{8'hda});
		chk("ack refclk", 8'h01, acks);
	endtask

	task automatic t_power();
		strap = 2'h0;
		pg = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		chk("powered down", 8'h00, {7'h00, run});
		watch();
		chk("legs stopped", 8'h00, {2'h0, tog});
		pg = 1'b1;
		wait_run(22);
		wr('{8'hda});
		chk("latched address", 8'h01, acks);
	endtask

	initial begin
		t_straps();
		t_block();
		t_pins();
		t_ref_stop();
		t_power();
		end_sim();
	end

	initial begin
		#2ms;
		err_count++;
		end_sim();
	end
endmodule // cbg_top_test
